//--- apms_pkg.sv
package apms_pkg;
   // link frame thresholds, counted in serial clock falling edges
   localparam int EDGE_GLITCH = 2;
   localparam int EDGE_WAKE = 10;
   localparam int EDGE_CONV = 16;
   localparam int EDGE_DUAL = 32;
   localparam int EDGE_TRACK = 13;
   localparam int CNT_W = 6;
   localparam int WORD_W = 16;

   // system clock and wake times
   localparam int CLK_PERIOD_NS = 100;
   localparam int WAKE_FULL_NS = 4000000;
   localparam int WAKE_PART_INT_NS = 4000;
   localparam int WAKE_PART_EXT_NS = 1000;
   localparam int WAKE_FULL_CYC =
      (WAKE_FULL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WAKE_PART_INT_CYC =
      (WAKE_PART_INT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WAKE_PART_EXT_CYC =
      (WAKE_PART_EXT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WAKE_W = 16;

   typedef enum logic [2:0] {
      APMS_NORMAL = 3'b001,
      APMS_PARTIAL = 3'b010,
      APMS_FULL = 3'b100
   } apms_mode_type;

   localparam apms_mode_type RESET_MODE = APMS_NORMAL;
endpackage

//--- apms_sequencer.sv
`timescale 1ns/1ns
`default_nettype none
module apms_sequencer
   import apms_pkg::*;
#(
   parameter int WAKE_FULL_CYCLES = WAKE_FULL_CYC
) (
   input wire logic clk, // system clock
   input wire logic rst_b, // active-low reset, synchronous on clk, asynchronous on the serial clock side
   input wire logic ce, // clock enable for the clk domain
   input wire logic sclk, // serial clock from the host
   input wire logic cs_b, // chip select from the host
   input wire logic ref_internal, // internal reference in use
   input wire logic [WORD_W-1:0] word_first, // first converter word
   input wire logic [WORD_W-1:0] word_second, // second converter word
   output logic result_out_first, // first result pin level
   output logic result_oe_first, // first result pin driven
   output logic result_out_second, // second result pin level
   output logic result_oe_second, // second result pin driven
   output logic track_hold_b, // low while track-and-hold holds
   output logic analog_on, // converter analog circuitry powered
   output logic ref_on, // reference and its buffer powered
   output logic conv_ready, // wake delay elapsed, results valid
   output apms_mode_type power_mode // current power mode
);
   import apms_pkg::*;

   initial begin
      if (WAKE_FULL_CYCLES < 1 || WAKE_FULL_CYCLES >= (1 << WAKE_W)) begin
         $error("WAKE_FULL_CYCLES out of range");
      end
      if (EDGE_DUAL >= (1 << CNT_W)) begin
         $error("CNT_W too narrow for the frame count");
      end
      if (WAKE_PART_INT_CYC >= (1 << WAKE_W)) begin
         $error("WAKE_W too narrow for the partial wake");
      end
      if (EDGE_GLITCH >= EDGE_WAKE || EDGE_WAKE >= EDGE_CONV) begin
         $error("frame thresholds out of order");
      end
   end

   localparam logic [WAKE_W-1:0] WAKE_FULL_LD = WAKE_FULL_CYCLES[WAKE_W-1:0];
   localparam logic [WAKE_W-1:0] WAKE_INT_LD =
      WAKE_PART_INT_CYC[WAKE_W-1:0];
   localparam logic [WAKE_W-1:0] WAKE_EXT_LD =
      WAKE_PART_EXT_CYC[WAKE_W-1:0];

   function automatic logic below(input logic [CNT_W-1:0] n,
                                  input int lim);
      below = n < lim[CNT_W-1:0];
   endfunction

   // ---------------- link side, on the serial clock ----------------
   logic first_reg; // set while no falling edge seen in this frame
   logic [CNT_W-1:0] edge_cnt_reg;
   logic frame_tog_reg;
   logic past13_reg;
   logic [2*WORD_W-1:0] shift_first_reg;
   logic [2*WORD_W-1:0] shift_second_reg;
   logic wake_cap_reg;

   // cs high arms a fresh frame even while the serial clock stands still;
   // reset reaches the link side directly, its clock is idle then
   always_ff @(negedge sclk or posedge cs_b or negedge rst_b) begin
      if (!rst_b || cs_b) begin
         first_reg <= 1'b1;
      end else begin
         first_reg <= 1'b0;
      end
   end

   // count stays put after cs rises so the clk side can read it stable
   always_ff @(negedge sclk) begin
      if (!cs_b) begin
         if (first_reg) begin
            edge_cnt_reg <= CNT_W'(1);
         end else if (below(edge_cnt_reg, EDGE_DUAL)) begin
            edge_cnt_reg <= edge_cnt_reg + CNT_W'(1);
         end
      end
   end

   // one toggle per frame with edges tells the clk side the count is new
   // without a known start the toggle would stay unknown for good
   always_ff @(negedge sclk or negedge rst_b) begin
      if (!rst_b) begin
         frame_tog_reg <= 1'b0;
      end else if (!cs_b && first_reg) begin
         frame_tog_reg <= ~frame_tog_reg;
      end
   end

   always_ff @(negedge sclk) begin
      if (!cs_b) begin
         if (first_reg) begin
            shift_first_reg <= {word_first, word_second};
            shift_second_reg <= {word_second, word_first};
         end else begin
            shift_first_reg <= {shift_first_reg[2*WORD_W-2:0], 1'b0};
            shift_second_reg <= {shift_second_reg[2*WORD_W-2:0], 1'b0};
         end
      end
   end

   // normal return to track: rising edge after the 13th falling edge
   always_ff @(posedge sclk or posedge cs_b or negedge rst_b) begin
      if (!rst_b || cs_b) begin
         past13_reg <= 1'b0;
      end else begin
         past13_reg <= !first_reg && !below(edge_cnt_reg, EDGE_TRACK);
      end
   end

   // power-down state taken at cs fall: the mode settles within eight
   // clk cycles of the cs rise, before the next frame opens, and a chain on the serial clock
   // would still show the previous frame at the first edge
   always_ff @(negedge cs_b or negedge rst_b) begin
      if (!rst_b) begin
         wake_cap_reg <= 1'b0;
      end else begin
         wake_cap_reg <= power_mode != APMS_NORMAL;
      end
   end

   logic bus_live;
   assign bus_live = !cs_b && (first_reg || below(edge_cnt_reg, EDGE_DUAL));

   // cs rising floats both pins at once, whatever the edge count
   assign result_oe_first = bus_live;
   assign result_oe_second = bus_live;
   assign result_out_first = shift_first_reg[2*WORD_W-1];
   assign result_out_second = shift_second_reg[2*WORD_W-1];

   // hold from cs fall; a waking part tracks again at its first edge
   always_comb begin
      if (cs_b) begin
         track_hold_b = 1'b1;
      end else if (wake_cap_reg) begin
         track_hold_b = !first_reg;
      end else begin
         track_hold_b = past13_reg;
      end
   end

   // ---------------- control side, on clk ----------------
   logic cs_s1_reg;
   logic cs_s2_reg;
   logic cs_prev_reg;
   logic tog_s1_reg;
   logic tog_s2_reg;
   logic tog_seen_reg;
   logic [CNT_W-1:0] cnt_s1_reg;
   logic [CNT_W-1:0] cnt_s2_reg;
   logic ref_s1_reg;
   logic ref_s2_reg;
   logic [1:0] rise_dly_reg;
   logic [WAKE_W-1:0] wake_cnt_reg;
   logic waking_reg;
   apms_mode_type mode_reg;
   apms_mode_type mode_next;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         cs_s1_reg <= 1'b1;
         cs_s2_reg <= 1'b1;
         cs_prev_reg <= 1'b1;
         tog_s1_reg <= 1'b0;
         tog_s2_reg <= 1'b0;
         cnt_s1_reg <= '0;
         cnt_s2_reg <= '0;
         ref_s1_reg <= 1'b0;
         ref_s2_reg <= 1'b0;
      end else if (ce) begin
         cs_s1_reg <= cs_b;
         cs_s2_reg <= cs_s1_reg;
         cs_prev_reg <= cs_s2_reg;
         tog_s1_reg <= frame_tog_reg;
         tog_s2_reg <= tog_s1_reg;
         cnt_s1_reg <= edge_cnt_reg;
         cnt_s2_reg <= cnt_s1_reg;
         ref_s1_reg <= ref_internal;
         ref_s2_reg <= ref_s1_reg;
      end
   end

   logic cs_rise;
   logic cs_fall;
   logic frame_end;
   logic [CNT_W-1:0] frame_edges;
   assign cs_rise = cs_s2_reg && !cs_prev_reg;
   assign cs_fall = !cs_s2_reg && cs_prev_reg;
   // two spare cycles let the frame toggle and count settle first
   assign frame_end = rise_dly_reg[1];
   assign frame_edges = (tog_s2_reg != tog_seen_reg) ? cnt_s2_reg : '0;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         rise_dly_reg <= '0;
         tog_seen_reg <= 1'b0;
      end else if (ce) begin
         rise_dly_reg <= {rise_dly_reg[0], cs_rise};
         if (frame_end) begin
            tog_seen_reg <= tog_s2_reg;
         end
      end
   end

   always_comb begin
      mode_next = mode_reg;
      unique case (mode_reg)
         APMS_NORMAL: begin
            if (below(frame_edges, EDGE_GLITCH)) begin
               mode_next = APMS_NORMAL;
            end else if (below(frame_edges, EDGE_WAKE)) begin
               mode_next = APMS_PARTIAL;
            end else begin
               mode_next = APMS_NORMAL;
            end
         end
         APMS_PARTIAL: begin
            if (below(frame_edges, EDGE_GLITCH)) begin
               mode_next = APMS_PARTIAL;
            end else if (below(frame_edges, EDGE_WAKE)) begin
               mode_next = APMS_FULL;
            end else begin
               mode_next = APMS_NORMAL;
            end
         end
         APMS_FULL: begin
            if (below(frame_edges, EDGE_WAKE)) begin
               mode_next = APMS_FULL;
            end else begin
               mode_next = APMS_NORMAL;
            end
         end
         default: begin
            mode_next = RESET_MODE;
         end
      endcase
   end

   // mode changes at frame_end, two clk cycles after the synchronised cs rise, no matter how the frame would have ended
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         mode_reg <= RESET_MODE;
      end else if (ce && frame_end) begin
         mode_reg <= mode_next;
      end
   end

   // wake timer runs from the dummy frame's cs fall
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         wake_cnt_reg <= '0;
         waking_reg <= 1'b0;
      end else if (ce) begin
         if (cs_fall && mode_reg == APMS_FULL) begin
            wake_cnt_reg <= WAKE_FULL_LD;
            waking_reg <= 1'b1;
         end else if (cs_fall && mode_reg == APMS_PARTIAL) begin
            wake_cnt_reg <= ref_s2_reg ? WAKE_INT_LD : WAKE_EXT_LD;
            waking_reg <= 1'b1;
         end else if (frame_end && mode_next != APMS_NORMAL) begin
            wake_cnt_reg <= '0;
            waking_reg <= 1'b0;
         end else if (wake_cnt_reg != '0) begin
            wake_cnt_reg <= wake_cnt_reg - WAKE_W'(1);
         end else if (!cs_s2_reg || mode_reg == APMS_NORMAL) begin
            waking_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         power_mode <= RESET_MODE;
      end else if (ce) begin
         power_mode <= mode_reg;
      end
   end

   // power rails: power-up starts with the dummy frame's cs fall
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         analog_on <= 1'b1;
      end else if (ce) begin
         analog_on <= mode_reg == APMS_NORMAL || waking_reg;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         ref_on <= 1'b1;
      end else if (ce) begin
         ref_on <= mode_reg != APMS_FULL || waking_reg;
      end
   end

   // external reference: a 16-clock dummy outlasts the 1 us wake
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         conv_ready <= 1'b1;
      end else if (ce) begin
         conv_ready <= mode_reg == APMS_NORMAL && wake_cnt_reg == '0;
      end
   end

endmodule
`default_nettype wire

//--- apms_checker.sv
`timescale 1ns/1ns
`default_nettype none
module apms_checker
   import apms_pkg::*;
#(
   parameter int WAKE_FULL_CYCLES = WAKE_FULL_CYC
) (
   input wire logic clk, // system clock
   input wire logic rst_b, // synchronous reset
   input wire logic ce, // clock enable
   input wire logic sclk, // serial clock
   input wire logic cs_b, // chip select
   input wire logic result_oe_first, // first pin driven
   input wire logic result_oe_second, // second pin driven
   input wire logic analog_on, // analog powered
   input wire logic ref_on, // reference powered
   input wire logic conv_ready, // results valid
   input wire apms_mode_type power_mode // current mode
);
   int edge_cnt;
   int last_n;
   int wake_cnt;
   logic full_wake;
   always_ff @(negedge sclk or posedge cs_b) begin
      if (cs_b)
         edge_cnt <= 0;
      else
         edge_cnt <= edge_cnt + 1;
   end
   // frames end well after their last edge, so this copy is settled
   always_ff @(posedge clk) begin
      if (!cs_b)
         last_n <= edge_cnt;
   end
   always_ff @(posedge clk) begin
      wake_cnt <= (!analog_on || conv_ready) ? 0 : wake_cnt + 1;
   end
   always_ff @(posedge clk) begin
      if (!rst_b || conv_ready)
         full_wake <= 1'b0;
      else if (power_mode == APMS_FULL && analog_on)
         full_wake <= 1'b1;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b || !ce);
   a_idle: assert property (p_idle) else $error("pin driven while idle");
   property p_idle; cs_b |-> !result_oe_first && !result_oe_second; endproperty
   a_open: assert property (p_open) else $error("pin not driven");
   property p_open; $fell(cs_b) |-> result_oe_first && result_oe_second;
   endproperty
   a_hot: assert property (p_hot) else $error("mode not one-hot");
   property p_hot; $onehot(power_mode); endproperty
   a_keep: assert property (p_keep) else $error("glitch changed mode");
   property p_keep; $rose(cs_b) && last_n < 2 |=> $stable(power_mode) [*8];
   endproperty
   a_drop: assert property (p_drop) else $error("aborted wake kept power");
   property p_drop; $rose(cs_b) && last_n < 2 && power_mode == APMS_PARTIAL
      |-> ##8 !analog_on; endproperty
   a_part: assert property (p_part) else $error("partial not entered");
   property p_part; $rose(cs_b) && last_n inside {[2:9]} &&
      power_mode == APMS_NORMAL |-> ##8 power_mode == APMS_PARTIAL; endproperty
   a_full: assert property (p_full) else $error("full not entered");
   property p_full; $rose(cs_b) && last_n inside {[2:9]} &&
      power_mode == APMS_PARTIAL |-> ##8 power_mode == APMS_FULL; endproperty
   a_up: assert property (p_up) else $error("long frame not normal");
   property p_up; $rose(cs_b) && last_n >= 10 |-> ##8 power_mode == APMS_NORMAL;
   endproperty
   a_ref: assert property (p_ref) else $error("reference off in partial");
   property p_ref; power_mode == APMS_PARTIAL |-> ref_on; endproperty
   a_off: assert property (p_off) else $error("reference on in full");
   property p_off; power_mode == APMS_FULL && !analog_on |-> !ref_on; endproperty
   a_wait: assert property (p_wait) else $error("full wake too short");
   property p_wait; $rose(conv_ready) && full_wake
      |-> wake_cnt >= WAKE_FULL_CYCLES - 2; endproperty
endmodule
bind apms_sequencer apms_checker #(.WAKE_FULL_CYCLES(WAKE_FULL_CYCLES))
   apms_checker_i (.clk, .rst_b, .ce, .sclk, .cs_b, .result_oe_first,
   .result_oe_second, .analog_on, .ref_on, .conv_ready, .power_mode);
`default_nettype wire

//--- apms_host.sv
`timescale 1ns/1ns
`default_nettype none
module apms_host
   import apms_pkg::*;
(
   output logic cs_b, // chip select to the block
   output logic sclk, // serial clock, still between frames
   input wire logic result_out_first, // first result pin
   input wire logic result_out_second // second result pin
);
   logic [WORD_W-1:0] cap_first;
   logic [WORD_W-1:0] cap_second;
   initial begin
      cs_b = 1'b1;
      sclk = 1'b1;
   end
   // a frame of n falling edges at 80 ns; n >= 10 is a wake dummy cycle
   task automatic frame(input int n);
      #17 cs_b = 1'b0;
      #100;
      repeat (n) begin
         #40 sclk = 1'b0;
         #40 sclk = 1'b1;
         cap_first = {cap_first[WORD_W-2:0], result_out_first};
         cap_second = {cap_second[WORD_W-2:0], result_out_second};
      end
      #200 cs_b = 1'b1;
      // long high time covers idle gap and acquisition
      #900;
   endtask
endmodule
`default_nettype wire

//--- apms_sequencer_bench.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin bad_count++; \
   $display("ERROR %0t: got %0h want %0h", $time, a, b); end end
module apms_sequencer_bench;
   import apms_pkg::*;
   localparam int WF = 50;
   logic clk = 1'b0;
   logic rst_b = 1'b1;
   logic ref_internal = 1'b0;
   logic cs_b, sclk, result_out_first, result_oe_first;
   logic result_out_second, result_oe_second, track_hold_b;
   logic analog_on, ref_on, conv_ready;
   apms_mode_type power_mode;
   int bad_count = 0;
   int num_checks = 0;
   realtime t0;
   always #50 clk = ~clk;
   apms_sequencer #(.WAKE_FULL_CYCLES(WF)) apms_sequencer_i (.clk, .rst_b,
      .ce(1'b1), .sclk, .cs_b, .ref_internal, .word_first(16'hA5C3),
      .word_second(16'h3C5A), .result_out_first, .result_oe_first,
      .result_out_second, .result_oe_second, .track_hold_b, .analog_on,
      .ref_on, .conv_ready, .power_mode);
   apms_host apms_host_i (.cs_b, .sclk, .result_out_first, .result_out_second);
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic go(input int n, input apms_mode_type m);
      apms_host_i.frame(n);
      `CHK(power_mode, m)
   endtask
   task automatic ready_in(input int lo, input int hi);
      int k;
      int el;
      k = 0;
      while (conv_ready !== 1'b1 && k < 1000) begin
         @(posedge clk);
         k++;
      end
      el = int'(($realtime - t0 - 17) / 100);
      `CHK(el >= lo && el <= hi, 1'b1)
   endtask
   task automatic t_reset;
      `CHK(power_mode, APMS_NORMAL)
      `CHK(conv_ready, 1'b1)
      `CHK(track_hold_b, 1'b1)
      $display("reset test done");
   endtask
   task automatic t_normal;
      go(16, APMS_NORMAL);
      `CHK(apms_host_i.cap_first, 16'hA5C3)
      `CHK(apms_host_i.cap_second, 16'h3C5A)
      go(1, APMS_NORMAL);
      go(12, APMS_NORMAL);
      $display("normal test done");
   endtask
   task automatic t_partial;
      go(2, APMS_PARTIAL);
      `CHK({analog_on, ref_on}, 2'h1)
      go(1, APMS_PARTIAL);
      `CHK(analog_on, 1'b0)
      go(16, APMS_NORMAL);
      `CHK(conv_ready, 1'b1)
      $display("partial test done");
   endtask
   task automatic t_full;
      go(9, APMS_PARTIAL);
      go(9, APMS_FULL);
      `CHK({analog_on, ref_on}, 2'h0)
      t0 = $realtime;
      go(10, APMS_NORMAL);
      `CHK(conv_ready, 1'b0)
      ready_in(WF, WF + 8);
      $display("full test done");
   endtask
   task automatic t_internal;
      go(3, APMS_PARTIAL);
      @(posedge clk);
      ref_internal <= 1'b1;
      repeat (3) @(posedge clk);
      t0 = $realtime;
      go(16, APMS_NORMAL);
      `CHK(conv_ready, 1'b0)
      ready_in(WAKE_PART_INT_CYC, WAKE_PART_INT_CYC + 8);
      $display("internal test done");
   endtask
   initial begin
      rst_b <= 1'b0;
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      repeat (2) @(posedge clk);
      t_reset();
      t_normal();
      t_partial();
      t_full();
      t_internal();
      tally_and_finish();
   end
   // whole run is about 28 us of frames and waits
   initial begin
      #400000;
      bad_count++;
      $display("ERROR %0t: watchdog expired", $time);
      tally_and_finish();
   end
endmodule
`default_nettype wire
